// file: pll_lock_ratio_status_test.sv
/*
  Self-checking bench for the loop lock supervision and ratio status block.
  Assumes plrs_top with short time-out counts and a one-cycle read port.
*/
`include "plrs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pll_lock_ratio_status_test;
  typedef struct packed {logic [31:0] v; logic [31:0] m;} plrs_exp_s;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        lock = 1'b0;
  logic        lclk = 1'b0;
  logic        ack = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic [15:0] ratio;
  logic        lclk_o;
  logic        load;
  logic        irq;
  logic        rd_seen = 1'b0;
  logic [31:0] seed = 32'h00000039;
  logic [31:0] r;
  int          tout_lim = 0;
  plrs_exp_s   expq[$];
  int          miscompares = 0;
  int          n_tests = 0;

  always #2.5 clk = ~clk;

  plrs_top #(.RATIO_W(16), .TOUT10_CYC(20), .TOUT11_CYC(22), .TOUT_LOW_CYC(16)) u_plrs_top (
    .REF_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .LOCK_DET_IN(lock), .LOOP_CLK_IN(lclk),
    .RATIO_ACK_IN(ack), .LOOP_CLK_OUT(lclk_o), .RATIO_OUT(ratio),
    .RATIO_LOAD_OUT(load), .IRQ_OUT(irq));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic stop_test();
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic check(logic [31:0] got, logic [31:0] exp, logic [31:0] msk);
    n_tests++;
    if ((got & msk) !== (exp & msk)) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  // The expectation is queued; the monitor compares when the data appear
  task automatic rreg(logic [7:0] a, logic [31:0] v, logic [31:0] m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    expq.push_back('{v, m});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg

  // Gated clock must equal the raw clock ANDed with the expected gate
  task automatic gate(logic g);
    repeat (4) @(negedge clk) check({31'h0, lclk_o}, {31'h0, lclk & g}, 32'h1);
  endtask : gate

  // ---------------------------------------------------------------------------
  // Monitor and random loop clock
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    rd_seen <= rd;
    lclk <= ^xs();
  end

  always @(negedge clk) begin
    if (rd_seen) begin
      if (expq.size() == 0) check(32'h00000001, 32'h00000000, 32'hFFFFFFFF); // Unnoted read
      else check(rdata, expq[0].v, expq[0].m);
      if (expq.size() != 0) void'(expq.pop_front());
    end else check(rdata, 32'h00000000, 32'hFFFFFFFF); // Read data stand one cycle only
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 7; i++) rreg(8'(i * 4), 32'h0, 32'hFFFFFFFF);
    gate(1'b0);
    @(posedge clk) ce <= 1'b0;
    wreg(`PLRS_OFS_MASK, 32'h0000000F);
    @(posedge clk) ce <= 1'b1;
    rreg(`PLRS_OFS_MASK, 32'h0, 32'hFFFFFFFF);
    @(posedge clk) lock <= 1'b1;
    wreg(`PLRS_OFS_ENABLE, 32'h1);
    repeat (6) @(posedge clk);
    rreg(`PLRS_OFS_STATUS, 32'h1, 32'h1);
    rreg(`PLRS_OFS_PENDING, 32'h1, 32'h7);
    rreg(`PLRS_OFS_PENDING, 32'h0, 32'h7);
    gate(1'b1);
    // Ratio change while the loop keeps running
    r = xs() & 32'h0000FFFF;
    wreg(`PLRS_OFS_RATIO, r);
    @(negedge clk);
    check({16'h0, ratio}, r, 32'h0000FFFF);
    check({31'h0, load}, 32'h1, 32'h1);
    @(posedge clk) ack <= 1'b1;
    for (int i = 0; i < 20 && load !== 1'b0; i++) @(negedge clk);
    if (load !== 1'b0) begin
      miscompares++;
      stop_test();
    end
    @(posedge clk) ack <= 1'b0;
    repeat (2) @(posedge clk);
    rreg(`PLRS_OFS_PENDING, 32'h4, 32'h4);
    rreg(`PLRS_OFS_STATUS, 32'h5, 32'h7);
    rreg(`PLRS_OFS_RATIO, r, 32'hFFFFFFFF);
    // Lock loss raises both edge flags and the interrupt
    wreg(`PLRS_OFS_MASK, 32'h3);
    @(posedge clk) lock <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk) check({31'h0, irq}, 32'h1, 32'h1);
    rreg(`PLRS_OFS_PENDING, 32'h3, 32'h3);
    @(negedge clk) check({31'h0, irq}, 32'h0, 32'h1);
    rreg(`PLRS_OFS_STATUS, 32'h0, 32'h1);
    gate(1'b0);
    wreg(`PLRS_OFS_CTRLB, 32'h10);
    repeat (3) @(posedge clk);
    gate(1'b1);
    rreg(`PLRS_OFS_CTRLB, 32'h10, 32'hFFFFFFFF);
    wreg(`PLRS_OFS_CTRLB, 32'h0);
    repeat (3) @(posedge clk);
    gate(1'b0);
    // Time-out per select code, seen through the masked interrupt
    wreg(`PLRS_OFS_MASK, 32'h8);
    for (int c = 0; c < 8; c++) begin
      wreg(`PLRS_OFS_ENABLE, 32'h0);
      wreg(`PLRS_OFS_CTRLB, 32'(c));
      rreg(`PLRS_OFS_PENDING, 32'h0, 32'hFFFFFFF0);
      wreg(`PLRS_OFS_ENABLE, 32'h1);
      // Bench limits: 16 cycles for codes 0 to 3, 20 for 4 and 5, 22 for 6 and 7
      tout_lim = (c >= 6) ? 22 : ((c >= 4) ? 20 : 16);
      repeat (tout_lim - 1) @(posedge clk);
      @(negedge clk) check({31'h0, irq}, 32'h0, 32'h1);
      @(negedge clk) check({31'h0, irq}, 32'h1, 32'h1);
    end
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule : pll_lock_ratio_status_test

`default_nettype wire

// file: plrs_consts.svh
/*
  Constants for the loop lock supervision and ratio-update status block:
  register offsets, field positions, reset values and timing counts.
  Assumes a 200 MHz register clock and a plain strobe register port.
*/
`ifndef PLRS_CONSTS_SVH
`define PLRS_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------------
`define PLRS_OFS_CTRLB    8'h00
`define PLRS_OFS_RATIO    8'h04
`define PLRS_OFS_STATUS   8'h08
`define PLRS_OFS_PENDING  8'h0C
`define PLRS_OFS_MASK     8'h10
`define PLRS_OFS_ENABLE   8'h14

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define PLRS_BIT_BYPASS   4
`define PLRS_BIT_RISE     0
`define PLRS_BIT_FALL     1
`define PLRS_BIT_RDY      2
`define PLRS_BIT_TOUT     3
`define PLRS_BIT_LOCK     0
`define PLRS_BIT_STRDY    1
`define PLRS_BIT_RUN      2

// ---------------------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------------------
`define PLRS_RST_CTRLB    5'h00
`define PLRS_RST_RATIO    16'h0000
`define PLRS_CLK_MHZ      200
`define PLRS_TOUT_10_MS   10
`define PLRS_TOUT_11_MS   11
`define PLRS_RATIO_APPLY  3'h4

`endif

// file: plrs_pkg.sv
/*
  Types for the loop lock supervision block.
  Assumes plrs_consts.svh is included by the design file.
*/
package plrs_pkg;
  typedef enum logic [1:0] {PLRS_IDLE, PLRS_APPLY, PLRS_DONE} plrs_ratio_e;
  typedef struct packed {
    logic rise;
    logic fall;
    logic rdy;
    logic tout;
  } plrs_irq_s;
endpackage : plrs_pkg

// file: plrs_top.sv
/*
  Lock supervision and ratio-update status of a fractional loop clock source.
  Assumes the lock detector and loop clock arrive from the analog loop as
  asynchronous pins, and software uses a plain strobe register port.
*/
`include "plrs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module plrs_top #(
  parameter int          RATIO_W     = 16,        // Loop ratio width
  parameter int unsigned TOUT10_CYC  = `PLRS_TOUT_10_MS * `PLRS_CLK_MHZ * 1000,
  parameter int unsigned TOUT11_CYC  = `PLRS_TOUT_11_MS * `PLRS_CLK_MHZ * 1000,
  parameter int unsigned TOUT_LOW_CYC = `PLRS_TOUT_10_MS * `PLRS_CLK_MHZ * 1000
) (
  input  wire logic               REF_CLK_IN,       // 200 MHz clock
  input  wire logic               RSTN_IN,          // Async reset, active low
  input  wire logic               CE_IN,            // Clock enable
  input  wire logic [7:0]         ADDR_IN,          // Register byte address
  input  wire logic [31:0]        WDATA_IN,         // Write data
  input  wire logic               WR_IN,            // Write strobe
  input  wire logic               RD_IN,            // Read strobe
  output logic      [31:0]        RDATA_OUT,        // Read data, cycle after strobe
  input  wire logic               LOCK_DET_IN,      // Raw lock from loop detector
  input  wire logic               LOOP_CLK_IN,      // Raw loop clock
  input  wire logic               RATIO_ACK_IN,     // Loop took the new ratio
  output logic                    LOOP_CLK_OUT,     // Gated loop clock
  output logic      [RATIO_W-1:0] RATIO_OUT,        // Ratio applied to the loop
  output logic                    RATIO_LOAD_OUT,   // Ratio load request level
  output logic                    IRQ_OUT           // Level interrupt
);

  // -------------------------------------------------------------------------
  // Elaboration checks
  // -------------------------------------------------------------------------
  // The ratio must fit one bus word
  if (RATIO_W < 1 || RATIO_W > 32) begin : g_bad_ratio_w
    $error("RATIO_W out of range");
  end
  // A zero limit would make the watchdog compare wrap
  if (TOUT_LOW_CYC < 1 || TOUT10_CYC < 1 || TOUT11_CYC < 1) begin : g_bad_tout
    $error("time-out too small");
  end

  // -------------------------------------------------------------------------
  // Reset release and input synchronisers
  // -------------------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) rst_sync <= 2'h0;
    else          rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  logic [1:0] lock_sync;
  logic [1:0] ack_sync;
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      lock_sync <= 2'h0;
      ack_sync  <= 2'h0;
    end else if (CE_IN) begin
      lock_sync <= {lock_sync[0], LOCK_DET_IN};
      ack_sync  <= {ack_sync[0], RATIO_ACK_IN};
    end
  end

  // -------------------------------------------------------------------------
  // Registers and state
  // -------------------------------------------------------------------------
  logic [4:0]           ctrlb, next_ctrlb;
  logic [RATIO_W-1:0]   ratio, next_ratio;
  logic [RATIO_W-1:0]   ratio_app, next_ratio_app;
  logic                 loop_en, next_loop_en;
  logic                 loop_locked_flag, next_loop_locked_flag;
  logic                 status_rdy, next_status_rdy;
  plrs_pkg::plrs_irq_s  pending, next_pending, mask, next_mask;
  plrs_pkg::plrs_ratio_e rstate, next_rstate;
  logic [31:0]          tout_cnt, next_tout_cnt;
  logic [31:0]          rdata, next_rdata;
  logic                 ack_prev, next_ack_prev;
  logic                 output_mask_bypass;
  logic [2:0]           lock_timeout_select;
  logic                 lock_raw;
  logic                 ack_s;

  assign output_mask_bypass  = ctrlb[`PLRS_BIT_BYPASS];
  assign lock_timeout_select = ctrlb[2:0];
  assign lock_raw            = lock_sync[1];
  assign ack_s               = ack_sync[1];

  // Time-out decode used by the watchdog compare and the checks
  function automatic logic [31:0] tout_limit(input logic [2:0] sel);
    if (sel[2] && sel[1]) tout_limit = TOUT11_CYC;
    else if (sel[2])      tout_limit = TOUT10_CYC;
    else                  tout_limit = TOUT_LOW_CYC;
  endfunction : tout_limit

  function automatic logic [31:0] irq_word(input plrs_pkg::plrs_irq_s v);
    irq_word = {28'h0000000, v.tout, v.rdy, v.fall, v.rise};
  endfunction : irq_word

  function automatic plrs_pkg::plrs_irq_s irq_from(input logic [31:0] w);
    irq_from = '{rise: w[`PLRS_BIT_RISE], fall: w[`PLRS_BIT_FALL],
                 rdy: w[`PLRS_BIT_RDY], tout: w[`PLRS_BIT_TOUT]};
  endfunction : irq_from

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  always_comb begin
    plrs_pkg::plrs_irq_s ev;
    ev                    = '0;
    next_ctrlb            = ctrlb;
    next_ratio            = ratio;
    next_ratio_app        = ratio_app;
    next_loop_en          = loop_en;
    next_status_rdy       = status_rdy;
    next_mask             = mask;
    next_rstate           = rstate;
    next_tout_cnt         = tout_cnt;
    next_ack_prev         = ack_s;
    next_rdata            = 32'h00000000;
    next_loop_locked_flag = loop_en & lock_raw;

    // Lock edges; a fall raises both flags so software always hears of it
    if (next_loop_locked_flag && !loop_locked_flag) ev.rise = 1'b1;
    if (!next_loop_locked_flag && loop_locked_flag) begin
      ev.fall = 1'b1;
      ev.rise = 1'b1;
    end

    // Lock watchdog, restarted whenever the loop is off or locked
    if (!loop_en || loop_locked_flag) next_tout_cnt = 32'h00000000;
    else if (tout_cnt == tout_limit(lock_timeout_select) - 32'h1) begin
      ev.tout       = 1'b1;
      next_tout_cnt = 32'h00000000;
    end else next_tout_cnt = tout_cnt + 32'h1;

    // Ratio hand-over runs beside the loop, never stopping it
    case (rstate)
      plrs_pkg::PLRS_IDLE: ;
      plrs_pkg::PLRS_APPLY:
        if (ack_s && !ack_prev) begin
          next_rstate = plrs_pkg::PLRS_DONE;
        end
      plrs_pkg::PLRS_DONE: begin
        ev.rdy      = 1'b1;
        next_rstate = plrs_pkg::PLRS_IDLE;
        // Status bit is only refreshed for updates made while stopped
        if (!loop_en) next_status_rdy = 1'b1;
      end
      default: next_rstate = plrs_pkg::PLRS_IDLE;
    endcase

    // Register writes
    if (WR_IN) begin
      if (ADDR_IN == `PLRS_OFS_CTRLB) next_ctrlb = WDATA_IN[4:0];
      else if (ADDR_IN == `PLRS_OFS_RATIO) begin
        next_ratio      = WDATA_IN[RATIO_W-1:0];
        next_ratio_app  = WDATA_IN[RATIO_W-1:0];
        next_rstate     = plrs_pkg::PLRS_APPLY;
        next_status_rdy = 1'b0;
      end
      else if (ADDR_IN == `PLRS_OFS_MASK) next_mask = irq_from(WDATA_IN);
      else if (ADDR_IN == `PLRS_OFS_ENABLE) next_loop_en = WDATA_IN[0];
    end

    // Reads; a pending read clears the flags, but a new event wins
    next_pending = pending;
    if (RD_IN) begin
      if (ADDR_IN == `PLRS_OFS_CTRLB) next_rdata = {27'h0000000, ctrlb};
      else if (ADDR_IN == `PLRS_OFS_RATIO) next_rdata = 32'(ratio);
      else if (ADDR_IN == `PLRS_OFS_STATUS)
        next_rdata = {29'h00000000, loop_en, status_rdy, loop_locked_flag};
      else if (ADDR_IN == `PLRS_OFS_PENDING) begin
        next_rdata   = irq_word(pending);
        next_pending = '0;
      end
      else if (ADDR_IN == `PLRS_OFS_MASK) next_rdata = irq_word(mask);
      else if (ADDR_IN == `PLRS_OFS_ENABLE) next_rdata = {31'h00000000, loop_en};
    end
    next_pending = next_pending | ev;
  end

  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ctrlb            <= `PLRS_RST_CTRLB;
      ratio            <= RATIO_W'(`PLRS_RST_RATIO);
      ratio_app        <= RATIO_W'(`PLRS_RST_RATIO);
      loop_en          <= 1'b0;
      loop_locked_flag <= 1'b0;
      status_rdy       <= 1'b0;
      pending          <= '0;
      mask             <= '0;
      rstate           <= plrs_pkg::PLRS_IDLE;
      tout_cnt         <= 32'h00000000;
      rdata            <= 32'h00000000;
      ack_prev         <= 1'b0;
    end else if (CE_IN) begin
      ctrlb            <= next_ctrlb;
      ratio            <= next_ratio;
      ratio_app        <= next_ratio_app;
      loop_en          <= next_loop_en;
      loop_locked_flag <= next_loop_locked_flag;
      status_rdy       <= next_status_rdy;
      pending          <= next_pending;
      mask             <= next_mask;
      rstate           <= next_rstate;
      tout_cnt         <= next_tout_cnt;
      rdata            <= next_rdata;
      ack_prev         <= next_ack_prev;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  // Gate level is registered; the clock itself passes a plain AND, so a
  // gate change may clip one loop clock pulse, accepted for a status block
  logic gate_open;
  assign gate_open = loop_en & (loop_locked_flag | output_mask_bypass);

  assign LOOP_CLK_OUT   = LOOP_CLK_IN & gate_open;
  assign RATIO_OUT      = ratio_app;
  assign RATIO_LOAD_OUT = (rstate == plrs_pkg::PLRS_APPLY);
  assign RDATA_OUT      = rdata;
  assign IRQ_OUT        = |(pending & mask);

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  lock_fall_both_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    CE_IN && $fell(loop_locked_flag) |-> pending.rise && pending.fall)
    else $error("lock loss did not raise both flags");

  gate_unlocked_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    !loop_locked_flag && !output_mask_bypass |-> !gate_open)
    else $error("output not gated while unlocked");

  bypass_open_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    loop_en && output_mask_bypass |-> gate_open)
    else $error("bypass did not open the gate");

  tout_code_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    lock_timeout_select[2] |-> tout_limit(lock_timeout_select) ==
      (lock_timeout_select[1] ? TOUT11_CYC : TOUT10_CYC))
    else $error("time-out code decode wrong");

  ratio_run_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    CE_IN && WR_IN && ADDR_IN == `PLRS_OFS_RATIO |=> ratio_app == RATIO_W'($past(WDATA_IN))
      && RATIO_LOAD_OUT && $stable(loop_en))
    else $error("running ratio write not taken");

  ratio_rdy_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    CE_IN && rstate == plrs_pkg::PLRS_DONE |=> pending.rdy)
    else $error("ratio-ready flag not set");

  lock_rise_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    CE_IN && $rose(loop_locked_flag) |-> pending.rise)
    else $error("lock gain not flagged");

  irq_level_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    (pending & mask) != '0 |-> IRQ_OUT)
    else $error("interrupt not raised");

  // Look-ahead properties that expect a change qualify their trigger with CE_IN, since a frozen
  // cycle advances no state but the reset synchroniser
  tout_fire_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    CE_IN && loop_en && !loop_locked_flag &&
      tout_cnt == tout_limit(lock_timeout_select) - 32'h1 |=> pending.tout)
    else $error("lock time-out not flagged");

  gate_out_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    !loop_en || (!loop_locked_flag && !output_mask_bypass) |-> !LOOP_CLK_OUT)
    else $error("loop clock passed while unlocked");

  ratio_keep_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    CE_IN && !(WR_IN && ADDR_IN == `PLRS_OFS_RATIO) |=> $stable(ratio_app))
    else $error("applied ratio changed without a write");

  ratio_done_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    CE_IN && rstate == plrs_pkg::PLRS_APPLY && ack_s && !ack_prev &&
      !(WR_IN && ADDR_IN == `PLRS_OFS_RATIO) |=> rstate == plrs_pkg::PLRS_DONE)
    else $error("ratio acknowledge not taken");

  rdy_sticky_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    pending.rdy && !(CE_IN && RD_IN && ADDR_IN == `PLRS_OFS_PENDING) |=> pending.rdy)
    else $error("ratio-ready flag dropped unread");

  rise_sticky_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    pending.rise && !(CE_IN && RD_IN && ADDR_IN == `PLRS_OFS_PENDING) |=> pending.rise)
    else $error("lock-rise flag dropped unread");

  fall_sticky_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    pending.fall && !(CE_IN && RD_IN && ADDR_IN == `PLRS_OFS_PENDING) |=> pending.fall)
    else $error("lock-fall flag dropped unread");

  rdata_idle_a: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    CE_IN && !RD_IN |=> RDATA_OUT == 32'h00000000)
    else $error("read data outside the read cycle");

endmodule : plrs_top

`default_nettype wire
